// ---- design/wssv_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module wssv_counter
    import wssv_pkg::*;
#(
    parameter int W = 7
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // control
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    input wire logic dec_i,
    // state
    output logic [W-1:0] count_o,
    output logic zero_o
);
    logic [W-1:0] cnt_d, cnt_q;

    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = load_val_i;
        end else if (dec_i && cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count_o = cnt_q;
    assign zero_o = (cnt_q == '0);
endmodule
`default_nettype wire

// ---- design/wssv_pkg.sv ----
package wssv_pkg;
    // =========================================
    // slope modes
    localparam logic [1:0] WSSV_SLOPE_NONE = 2'h0;
    localparam logic [1:0] WSSV_SLOPE_UP = 2'h1;
    localparam logic [1:0] WSSV_SLOPE_DOWN = 2'h2;
    // =========================================
    // stepper modes
    localparam logic [1:0] WSSV_STEP_OFF = 2'h0;
    localparam logic [1:0] WSSV_STEP_MULTI = 2'h1;
    localparam logic [1:0] WSSV_STEP_SINGLE = 2'h2;
    // =========================================
    // limits and sizes
    localparam int WSSV_NUM_SCHED = 100;
    localparam int WSSV_NUM_STEPPERS = 10;
    localparam int WSSV_STEPS_PER = 10;
    localparam logic [6:0] WSSV_SCHED_MAX = 7'h63;
    localparam logic [6:0] WSSV_SLOPE_MIN = 7'h01;
    localparam logic [6:0] WSSV_SLOPE_MAX = 7'h63;
    localparam logic [13:0] WSSV_COUNT_MAX = 14'h270F;
    localparam int WSSV_END_DIV = 4;
    localparam int WSSV_END_SHIFT = 2;
    localparam int WSSV_VALVES = 8;
    // =========================================
    // weld phase encoding
    typedef enum logic [1:0] {
        WSSV_PH_IDLE = 2'b00,
        WSSV_PH_WELD = 2'b01,
        WSSV_PH_SLOPE = 2'b10,
        WSSV_PH_WAIT = 2'b11
    } wssv_phase_t;
endpackage

// ---- design/wssv_top.sv ----
// Operation
// - down-slope ramp starts only after the weld interval ends.
// - in repeat or pulsation, ramp follows only the last impulse.
// - slope cycles are added on top of weld cycles.
// - seam sequences start down-slope when final sloped initiation releases.
// - single-schedule down-slope ends at a quarter of programmed current.
// - current changes each cycle by (start minus end) over slope count.
// - chained schedule gives the end current instead of quarter default.
// - valve code nibbles drive valves 4..1 and 8..5, zero is none.
// - program mode lights lamps from edited code, valves stay off.
// - up to ten steps per stepper in multi mode (100 in single mode), each holding a count 0 to 9999.
// - optional alarm output once the final step completes.
// - after final step, return to start by manual or automatic reset.
// - decrement only on real weld: time, current, both weld switches.
// - multi mode gives stepper n schedules n0 through n9.
// - single mode uses one counter over schedules 0 to 99.
// - a stepper may act as plain weld down-counter.
// - new step selects that step's schedule and its parameters.
// - slope count accepted from 1 to 99 cycles.
// - slope mode zero means no ramp at programmed current.
`timescale 1ns/1ps
`default_nettype none
module wssv_top
    import wssv_pkg::*;
#(
    parameter int NUM_STEPPERS = WSSV_NUM_STEPPERS,
    parameter int STEPS_PER = WSSV_STEPS_PER
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // line-frequency cycle tick
    input wire logic cycle_tick_i,
    // sequence control from the sequencer
    input wire logic weld_start_i,
    input wire logic last_impulse_i,
    input wire logic seam_mode_i,
    input wire logic init_held_i,
    input wire logic [6:0] weld_cycles_i,
    input wire logic [6:0] pct_i,
    input wire logic [1:0] slope_mode_i,
    input wire logic [6:0] slope_count_i,
    input wire logic chained_i,
    input wire logic [6:0] next_pct_i,
    // valves
    input wire logic [7:0] valve_code_i,
    input wire logic prog_mode_i,
    input wire logic seq_active_i,
    // weld enable switches
    input wire logic ext_weld_sw_i,
    input wire logic panel_weld_i,
    // stepper configuration
    input wire logic [1:0] step_mode_i,
    input wire logic [3:0] stepper_sel_i,
    input wire logic [6:0] last_step_i,
    input wire logic alarm_en_i,
    input wire logic auto_reset_i,
    input wire logic manual_reset_i,
    // step count programming
    input wire logic cnt_wr_i,
    input wire logic [6:0] cnt_wr_sched_i,
    input wire logic [13:0] cnt_wr_val_i,
    // outputs
    output logic current_on_o,
    output logic [6:0] current_pct_o,
    output logic [WSSV_VALVES-1:0] valve_o,
    output logic [WSSV_VALVES-1:0] lamp_o,
    output logic [6:0] active_sched_o,
    output logic [13:0] step_count_o,
    output logic end_of_stepper_o,
    output logic alarm_o
);
    // =========================================
    // slope engine
    wssv_phase_t ph_d, ph_q;
    logic [6:0] pct_d, pct_q, step_d, step_q, end_d, end_q;
    logic down_d, down_q, last_d, last_q;
    logic [6:0] wc_cnt;
    logic wc_zero, wc_load, wc_dec;
    logic [6:0] sc_cnt;
    logic sc_zero, sc_load, sc_dec;
    logic [6:0] end_pct;
    logic [6:0] slope_n;
    logic weld_done;

    // clamp slope count to its legal window
    always_comb begin
        slope_n = slope_count_i;
        if (slope_n < WSSV_SLOPE_MIN) begin
            slope_n = WSSV_SLOPE_MIN;
        end else if (slope_n > WSSV_SLOPE_MAX) begin
            slope_n = WSSV_SLOPE_MAX;
        end
    end

    // chained schedule supplies the end level, else a quarter of own level
    assign end_pct = chained_i ? next_pct_i : (pct_i >> WSSV_END_SHIFT);

    wssv_counter #(.W(7)) u_weld_cnt (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(wc_load),
        .load_val_i(weld_cycles_i),
        .dec_i(wc_dec),
        .count_o(wc_cnt),
        .zero_o(wc_zero)
    );

    wssv_counter #(.W(7)) u_slope_cnt (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(sc_load),
        .load_val_i(slope_n),
        .dec_i(sc_dec),
        .count_o(sc_cnt),
        .zero_o(sc_zero)
    );

    assign weld_done = wc_zero || (wc_cnt == 7'h01 && cycle_tick_i);

    always_comb begin
        ph_d = ph_q;
        pct_d = pct_q;
        step_d = step_q;
        end_d = end_q;
        down_d = down_q;
        last_d = last_q;
        wc_load = 1'b0;
        wc_dec = 1'b0;
        sc_load = 1'b0;
        sc_dec = 1'b0;
        case (ph_q)
            WSSV_PH_IDLE: begin
                if (weld_start_i) begin
                    ph_d = WSSV_PH_WELD;
                    wc_load = 1'b1;
                    pct_d = pct_i;
                    // mode zero never ramps
                    down_d = (slope_mode_i == WSSV_SLOPE_DOWN);
                    last_d = last_impulse_i;
                    end_d = end_pct;
                    // integer divide; remainder is dropped, so the last cycle can stay above the end level
                    step_d = (pct_i > end_pct) ? 7'((pct_i - end_pct) / slope_n) : 7'h00;
                end
            end
            WSSV_PH_WELD: begin
                wc_dec = cycle_tick_i;
                if (weld_done && cycle_tick_i || wc_zero) begin
                    if (!down_q || !last_q) begin
                        // earlier impulses end without a ramp
                        ph_d = WSSV_PH_IDLE;
                    end else if (seam_mode_i) begin
                        ph_d = WSSV_PH_WAIT;
                    end else begin
                        // ramp only after the full weld interval
                        ph_d = WSSV_PH_SLOPE;
                        sc_load = 1'b1;
                    end
                end
            end
            WSSV_PH_WAIT: begin
                // seam holds current until the initiation is let go
                if (!init_held_i) begin
                    ph_d = WSSV_PH_SLOPE;
                    sc_load = 1'b1;
                end
            end
            WSSV_PH_SLOPE: begin
                if (cycle_tick_i) begin
                    sc_dec = 1'b1;
                    pct_d = (pct_q > end_q + step_q) ? 7'(pct_q - step_q) : end_q;
                    if (sc_cnt == 7'h01) begin
                        ph_d = WSSV_PH_IDLE;
                    end
                end
            end
            default: begin
                ph_d = WSSV_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ph_q <= WSSV_PH_IDLE;
            pct_q <= 7'h00;
            step_q <= 7'h00;
            end_q <= 7'h00;
            down_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            pct_q <= pct_d;
            step_q <= step_d;
            end_q <= end_d;
            down_q <= down_d;
            last_q <= last_d;
        end
    end

    logic on_q;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            on_q <= 1'b0;
        end else begin
            on_q <= (ph_d != WSSV_PH_IDLE);
        end
    end
    assign current_on_o = on_q;
    assign current_pct_o = pct_q;

    // =========================================
    // valves
    wssv_valve_dec u_valves (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .code_i(valve_code_i),
        .prog_mode_i(prog_mode_i),
        .active_i(seq_active_i),
        .valve_o(valve_o),
        .lamp_o(lamp_o)
    );

    // =========================================
    // stepper
    logic [13:0] cnt_mem [WSSV_NUM_SCHED];
    logic [6:0] stp_d [NUM_STEPPERS];
    logic [6:0] stp_q [NUM_STEPPERS];
    logic [13:0] rem_d, rem_q;
    logic eos_d, eos_q, alarm_d, alarm_q;
    logic [6:0] sched_d, sched_q;
    logic real_weld, weld_end, at_last;
    logic [3:0] sel;
    logic [6:0] cur_step, base, lim;

    // only count welds that really carried current
    assign real_weld = weld_cycles_i != 7'h00 && pct_i != 7'h00 && ext_weld_sw_i && panel_weld_i;
    assign weld_end = (ph_q != WSSV_PH_IDLE) && (ph_d == WSSV_PH_IDLE);
    assign sel = (step_mode_i == WSSV_STEP_SINGLE) ? 4'h0 : stepper_sel_i;
    assign cur_step = stp_q[sel];
    assign base = (step_mode_i == WSSV_STEP_MULTI) ? 7'(sel * 10) : 7'h00;
    assign lim = (step_mode_i == WSSV_STEP_MULTI) ? 7'(base + 7'h09) : WSSV_SCHED_MAX;
    assign at_last = cur_step >= last_step_i || cur_step >= lim;

    always_ff @(posedge mclk_i) begin
        if (cnt_wr_i && cnt_wr_val_i <= WSSV_COUNT_MAX && cnt_wr_sched_i <= WSSV_SCHED_MAX) begin
            cnt_mem[cnt_wr_sched_i] <= cnt_wr_val_i;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_STEPPERS; i++) begin
            stp_d[i] = stp_q[i];
        end
        rem_d = rem_q;
        eos_d = eos_q;
        alarm_d = alarm_q;
        sched_d = sched_q;
        if (step_mode_i == WSSV_STEP_OFF) begin
            eos_d = 1'b0;
            alarm_d = 1'b0;
        end else if (eos_q) begin
            if (manual_reset_i || auto_reset_i) begin
                stp_d[sel] = base;
                rem_d = cnt_mem[base];
                sched_d = base;
                eos_d = 1'b0;
                alarm_d = 1'b0;
            end
        end else if (weld_end && real_weld) begin
            if (rem_q > 14'h0001) begin
                // same step, parameters unchanged
                rem_d = 14'(rem_q - 14'h0001);
            end else if (at_last) begin
                rem_d = 14'h0000;
                eos_d = 1'b1;
                alarm_d = alarm_en_i;
            end else begin
                stp_d[sel] = 7'(cur_step + 7'h01);
                rem_d = cnt_mem[7'(cur_step + 7'h01)];
                // next weld runs this step's whole schedule
                sched_d = 7'(cur_step + 7'h01);
            end
        end else if (rem_q == 14'h0000 && !weld_end) begin
            rem_d = cnt_mem[cur_step];
            sched_d = cur_step;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_STEPPERS; i++) begin
                stp_q[i] <= 7'(i * 10);
            end
            rem_q <= 14'h0000;
            eos_q <= 1'b0;
            alarm_q <= 1'b0;
            sched_q <= 7'h00;
        end else begin
            for (int i = 0; i < NUM_STEPPERS; i++) begin
                stp_q[i] <= stp_d[i];
            end
            rem_q <= rem_d;
            eos_q <= eos_d;
            alarm_q <= alarm_d;
            sched_q <= sched_d;
        end
    end

    assign active_sched_o = sched_q;
    assign step_count_o = rem_q;
    assign end_of_stepper_o = eos_q;
    assign alarm_o = alarm_q;

    // =========================================
    // checks
    a_slope_after_weld: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ph_q == WSSV_PH_SLOPE) |-> !$past(ph_q == WSSV_PH_IDLE)) else $error("slope without weld");
    a_no_slope_mode0: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ph_q == WSSV_PH_SLOPE) |-> down_q) else $error("ramp with slope off");
    a_slope_last_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ph_q == WSSV_PH_SLOPE) |-> last_q) else $error("ramp between impulses");
    a_seam_waits: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ph_q == WSSV_PH_WAIT && init_held_i) |=> ph_q == WSSV_PH_WAIT) else $error("seam ramp early");
    a_pct_not_below: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ph_q == WSSV_PH_SLOPE) |-> pct_q >= end_q) else $error("current under end level");
    a_end_quarter: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ph_q == WSSV_PH_IDLE && weld_start_i && !chained_i) |=> end_q == $past(pct_i) >> 2)
        else $error("bad default end level");
    a_end_chained: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ph_q == WSSV_PH_IDLE && weld_start_i && chained_i) |=> end_q == $past(next_pct_i))
        else $error("bad chained end level");
    a_no_fake_count: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (weld_end && !real_weld && rem_q != 14'h0000) |=> rem_q == $past(rem_q))
        else $error("counted a no-weld");
    a_alarm_needs_end: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        alarm_o |-> end_of_stepper_o) else $error("alarm without end");
    a_reset_clears: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (eos_q && manual_reset_i && step_mode_i != WSSV_STEP_OFF) |=> !eos_q) else $error("reset ignored");

    c_slope_run: cover property (@(posedge mclk_i) ph_q == WSSV_PH_SLOPE ##1 ph_q == WSSV_PH_IDLE);
    c_seam_release: cover property (@(posedge mclk_i) ph_q == WSSV_PH_WAIT ##1 ph_q == WSSV_PH_SLOPE);
    c_step_advance: cover property (@(posedge mclk_i) weld_end && real_weld && rem_q == 14'h0001 && !at_last);
    c_end_alarm: cover property (@(posedge mclk_i) $rose(alarm_o));
endmodule
`default_nettype wire

// ---- design/wssv_valve_dec.sv ----
`timescale 1ns/1ps
`default_nettype none
module wssv_valve_dec
    import wssv_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // code and mode
    input wire logic [7:0] code_i,
    input wire logic prog_mode_i,
    input wire logic active_i,
    // outputs
    output logic [WSSV_VALVES-1:0] valve_o,
    output logic [WSSV_VALVES-1:0] lamp_o
);
    logic [WSSV_VALVES-1:0] valve_d, valve_q, lamp_d, lamp_q;

    // =========================================
    // decode
    always_comb begin
        // low nibble is valves 4..1, high nibble valves 8..5; bit order matches valve number
        lamp_d = code_i;
        valve_d = code_i;
        if (prog_mode_i) begin
            // lamps preview the edited code but solenoids stay dead
            valve_d = '0;
        end else if (!active_i) begin
            valve_d = '0;
            lamp_d = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            valve_q <= '0;
            lamp_q <= '0;
        end else begin
            valve_q <= valve_d;
            lamp_q <= lamp_d;
        end
    end

    assign valve_o = valve_q;
    assign lamp_o = lamp_q;

    a_prog_valves_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        prog_mode_i |=> valve_o == '0) else $error("valve energized in program mode");
    a_lamp_follow_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        prog_mode_i |=> lamp_o == $past(code_i)) else $error("lamps differ from code");
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wssv_pkg::*;
    logic mclk_i, rst_n_i, cycle_tick_i, weld_start_i, last_impulse_i, seam_mode_i, init_held_i;
    logic [6:0] weld_cycles_i, pct_i, slope_count_i, next_pct_i, last_step_i, cnt_wr_sched_i;
    logic [1:0] slope_mode_i, step_mode_i;
    logic chained_i, prog_mode_i, seq_active_i, ext_weld_sw_i, panel_weld_i;
    logic [7:0] valve_code_i;
    logic [3:0] stepper_sel_i;
    logic alarm_en_i, auto_reset_i, manual_reset_i, cnt_wr_i;
    logic [13:0] cnt_wr_val_i, step_count_o;
    logic current_on_o, end_of_stepper_o, alarm_o;
    logic [6:0] current_pct_o, active_sched_o;
    logic [WSSV_VALVES-1:0] valve_o, lamp_o;
    int bad_count, compares, tk, dr, bd;
    logic [6:0] lo, wc, p, sc, stp, e;
    wssv_top wssv_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cycle_tick_i(cycle_tick_i),
        .weld_start_i(weld_start_i), .last_impulse_i(last_impulse_i), .seam_mode_i(seam_mode_i),
        .init_held_i(init_held_i), .weld_cycles_i(weld_cycles_i), .pct_i(pct_i),
        .slope_mode_i(slope_mode_i), .slope_count_i(slope_count_i), .chained_i(chained_i),
        .next_pct_i(next_pct_i), .valve_code_i(valve_code_i), .prog_mode_i(prog_mode_i),
        .seq_active_i(seq_active_i), .ext_weld_sw_i(ext_weld_sw_i), .panel_weld_i(panel_weld_i),
        .step_mode_i(step_mode_i), .stepper_sel_i(stepper_sel_i), .last_step_i(last_step_i),
        .alarm_en_i(alarm_en_i), .auto_reset_i(auto_reset_i), .manual_reset_i(manual_reset_i),
        .cnt_wr_i(cnt_wr_i), .cnt_wr_sched_i(cnt_wr_sched_i), .cnt_wr_val_i(cnt_wr_val_i),
        .current_on_o(current_on_o), .current_pct_o(current_pct_o), .valve_o(valve_o),
        .lamp_o(lamp_o), .active_sched_o(active_sched_o), .step_count_o(step_count_o),
        .end_of_stepper_o(end_of_stepper_o), .alarm_o(alarm_o));
    wssv_machine wssv_machine_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cycle_tick_o(cycle_tick_i));
    // =========================================
    // checking and closing
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // bottom level: quarter of start unless the chained schedule supplies it
    function automatic logic [6:0] end_lvl(input logic [6:0] pc, np, input logic ch);
        return ch ? np : (pc >> 2);
    endfunction
    function automatic logic [6:0] step_of(input logic [6:0] pc, np, s, input logic ch);
        return (pc - end_lvl(pc, np, ch)) / s;
    endfunction
    // =========================================
    // one weld impulse, watching current level per line cycle
    task automatic weld(input logic [6:0] w, pc, s, np, stp_e, input logic [1:0] sm,
        input logic ch, lst, output int ticks, drop, output logic [6:0] low, output int bad);
        int n;
        logic [6:0] prev;
        n = 0;
        ticks = 0;
        drop = -1;
        bad = 0;
        weld_cycles_i <= w;
        pct_i <= pc;
        slope_count_i <= s;
        next_pct_i <= np;
        slope_mode_i <= sm;
        chained_i <= ch;
        last_impulse_i <= lst;
        weld_start_i <= 1'b1;
        @(posedge mclk_i);
        weld_start_i <= 1'b0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (current_on_o !== 1'b1 && n < 10);
        chk("on_seen", 16'h1, {15'h0, current_on_o});
        chk("pct_at_start", {9'h0, pc}, {9'h0, current_pct_o});
        prev = pc;
        // last level lands with current off, so look at the level before leaving
        while (n < 3000) begin
            if (current_pct_o !== prev) begin
                if (prev - current_pct_o !== stp_e) bad++;
                if (drop < 0) drop = ticks;
                prev = current_pct_o;
            end
            if (current_on_o !== 1'b1) break;
            if (cycle_tick_i === 1'b1) ticks++;
            @(posedge mclk_i);
            n++;
        end
        chk("on_ended", 16'h0, {15'h0, current_on_o});
        low = prev;
        repeat (3) @(posedge mclk_i);
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    initial begin
        #400000;
        bad_count++;
        stop_test();
    end
    initial begin
        {rst_n_i, weld_start_i, last_impulse_i, seam_mode_i, init_held_i, chained_i} = '0;
        {weld_cycles_i, pct_i, slope_count_i, next_pct_i, last_step_i, cnt_wr_sched_i} = '0;
        {slope_mode_i, step_mode_i, valve_code_i, stepper_sel_i, cnt_wr_val_i} = '0;
        {prog_mode_i, seq_active_i, alarm_en_i, auto_reset_i, manual_reset_i, cnt_wr_i} = '0;
        ext_weld_sw_i = 1'b1;
        panel_weld_i = 1'b1;
        bad_count = 0;
        compares = 0;
        void'($urandom(32'h833e9d81));
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        // valve decode in operate and program mode, corners first
        seq_active_i <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            valve_code_i <= (i < 2) ? 8'hF0 : (i < 4) ? 8'h0F : 8'($urandom);
            prog_mode_i <= i[0];
            repeat (4) @(posedge mclk_i);
            chk("valve", {8'h0, i[0] ? 8'h00 : valve_code_i}, {8'h0, valve_o});
            chk("lamp", {8'h0, valve_code_i}, {8'h0, lamp_o});
        end
        prog_mode_i <= 1'b0;
        $display("test valves done");
        // slope table: single schedule, chained, one-cycle slope, then random
        for (int i = 0; i < 8; i++) begin
            wc = (i == 0) ? 7'h19 : (i == 1) ? 7'h14 : (i == 2) ? 7'h03 : 7'($urandom_range(1, 20));
            p = (i == 0) ? 7'h50 : (i == 1) ? 7'h4B : (i == 2) ? 7'h63 : 7'($urandom_range(40, 99));
            sc = (i == 0) ? 7'h0A : (i == 1) ? 7'h0F : (i == 2) ? 7'h01 : 7'($urandom_range(1, 20));
            stp = step_of(p, 7'h0F, sc, i == 1);
            e = end_lvl(p, 7'h0F, i == 1);
            weld(wc, p, sc, 7'h0F, stp, WSSV_SLOPE_DOWN, i == 1, 1'b1, tk, dr, lo, bd);
            chk("on_ticks", 16'(wc + sc), 16'(tk));
            chk("late_drop", 16'h1, {15'h0, dr >= int'(wc)});
            chk("step_size", 16'h0, 16'(bd));
            chk("end_level", 16'h1, {15'h0, lo == p - sc * stp && lo >= e});
        end
        weld(7'h04, 7'h40, 7'h00, 7'h0F, 7'h30, WSSV_SLOPE_DOWN, 1'b0, 1'b1, tk, dr, lo, bd);
        chk("min_slope", 16'(7'h04 + WSSV_SLOPE_MIN), 16'(tk));
        chk("min_step", 16'h0, 16'(bd));
        // seam: current held past the weld until the initiation opens
        seam_mode_i <= 1'b1;
        init_held_i <= 1'b1;
        fork
            weld(7'h05, 7'h40, 7'h04, 7'h0F, 7'h0C, WSSV_SLOPE_DOWN, 1'b0, 1'b1, tk, dr, lo, bd);
            begin
                repeat (60) @(posedge mclk_i);
                init_held_i <= 1'b0;
            end
        join
        seam_mode_i <= 1'b0;
        chk("seam_hold", 16'h1, {15'h0, tk > 9});
        chk("seam_drop", 16'(tk - 3), 16'(dr));
        chk("seam_step", 16'h0, 16'(bd));
        $display("test down slope done");
        weld(7'h07, 7'h3C, 7'h05, 7'h0F, 7'h00, WSSV_SLOPE_NONE, 1'b0, 1'b1, tk, dr, lo, bd);
        chk("flat_ticks", 16'h7, 16'(tk));
        chk("flat_drop", 16'hFFFF, 16'(dr));
        weld(7'h06, 7'h50, 7'h0A, 7'h0F, 7'h06, WSSV_SLOPE_DOWN, 1'b0, 1'b0, tk, dr, lo, bd);
        chk("mid_ticks", 16'h6, 16'(tk));
        chk("mid_drop", 16'hFFFF, 16'(dr));
        $display("test no slope done");
        // stepper 1 owns schedules 10..19; last step 11
        stepper_sel_i <= 4'h1;
        last_step_i <= 7'h0B;
        alarm_en_i <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            cnt_wr_i <= 1'b1;
            cnt_wr_sched_i <= 7'(10 + i);
            cnt_wr_val_i <= 14'(2 - i);
            @(posedge mclk_i);
        end
        cnt_wr_i <= 1'b0;
        // count memory has no reset: fill it before the stepper reloads from it
        step_mode_i <= WSSV_STEP_MULTI;
        repeat (4) @(posedge mclk_i);
        chk("first_sched", 16'hA, {9'h0, active_sched_o});
        chk("first_count", 16'h2, {2'h0, step_count_o});
        panel_weld_i <= 1'b0;
        weld(7'h02, 7'h32, 7'h01, 7'h0F, 7'h00, WSSV_SLOPE_NONE, 1'b0, 1'b1, tk, dr, lo, bd);
        chk("no_weld_count", 16'h2, {2'h0, step_count_o});
        panel_weld_i <= 1'b1;
        weld(7'h02, 7'h32, 7'h01, 7'h0F, 7'h00, WSSV_SLOPE_NONE, 1'b0, 1'b1, tk, dr, lo, bd);
        chk("count_dec", 16'h1, {2'h0, step_count_o});
        weld(7'h02, 7'h32, 7'h01, 7'h0F, 7'h00, WSSV_SLOPE_NONE, 1'b0, 1'b1, tk, dr, lo, bd);
        chk("next_sched", 16'hB, {9'h0, active_sched_o});
        chk("next_count", 16'h1, {2'h0, step_count_o});
        chk("not_end", 16'h0, {15'h0, end_of_stepper_o});
        weld(7'h02, 7'h32, 7'h01, 7'h0F, 7'h00, WSSV_SLOPE_NONE, 1'b0, 1'b1, tk, dr, lo, bd);
        chk("end_flag", 16'h1, {15'h0, end_of_stepper_o});
        chk("alarm", 16'h1, {15'h0, alarm_o});
        // max count kept, out-of-range write dropped
        cnt_wr_i <= 1'b1;
        cnt_wr_sched_i <= 7'h0A;
        cnt_wr_val_i <= WSSV_COUNT_MAX;
        @(posedge mclk_i);
        cnt_wr_val_i <= 14'h2710;
        @(posedge mclk_i);
        cnt_wr_i <= 1'b0;
        manual_reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        manual_reset_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk("rst_end", 16'h0, {15'h0, end_of_stepper_o});
        chk("rst_alarm", 16'h0, {15'h0, alarm_o});
        chk("rst_sched", 16'hA, {9'h0, active_sched_o});
        chk("rst_count", 16'h270F, {2'h0, step_count_o});
        // mid-run reset, then one counter over schedules 0 and 1 restarting by itself
        for (int i = 0; i < 2; i++) begin
            cnt_wr_i <= 1'b1;
            cnt_wr_sched_i <= 7'(i);
            cnt_wr_val_i <= 14'h0001;
            @(posedge mclk_i);
        end
        cnt_wr_i <= 1'b0;
        rst_n_i <= 1'b0;
        step_mode_i <= WSSV_STEP_SINGLE;
        last_step_i <= 7'h01;
        alarm_en_i <= 1'b0;
        auto_reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk("single_count", 16'h1, {2'h0, step_count_o});
        weld(7'h02, 7'h32, 7'h01, 7'h0F, 7'h00, WSSV_SLOPE_NONE, 1'b0, 1'b1, tk, dr, lo, bd);
        chk("single_next", 16'h1, {9'h0, active_sched_o});
        weld(7'h02, 7'h32, 7'h01, 7'h0F, 7'h00, WSSV_SLOPE_NONE, 1'b0, 1'b1, tk, dr, lo, bd);
        chk("auto_sched", 16'h0, {9'h0, active_sched_o});
        chk("auto_count", 16'h1, {2'h0, step_count_o});
        chk("auto_end", 16'h0, {15'h0, end_of_stepper_o});
        chk("no_alarm", 16'h0, {15'h0, alarm_o});
        $display("test stepper done");
        stop_test();
    end
endmodule
`default_nettype wire

// ---- verification/wssv_machine.sv ----
`timescale 1ns/1ps
`default_nettype none
// =========================================
// welding machine side: line cycle source
module wssv_machine #(
    parameter int TICK_DIV = 4
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // line cycle pulse
    output logic cycle_tick_o
);
    int div_q;
    // short line cycle keeps the run brief; the seam test's 60-clock release relies on this ratio to clock
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            div_q <= 0;
            cycle_tick_o <= 1'b0;
        end else begin
            div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
            cycle_tick_o <= (div_q == TICK_DIV - 1);
        end
    end
endmodule
`default_nettype wire
